// ==== common/pdb_consts.svh ====
// Offsets, field positions, reset values and bus codes for the port group
// Assumes a 32-bit AXI4-Lite slave; register index times four is the address
`ifndef PDB_CONSTS_SVH
`define PDB_CONSTS_SVH

// ======================================================
// Register indices
`define PDB_IDX_PORT_A 6'h06
`define PDB_IDX_PORT_B 6'h07
`define PDB_IDX_PORT_C 6'h08
`define PDB_IDX_PORT_D 6'h09

// ======================================================
// Field positions within a data word
`define PDB_LO_BYTE_LSB 0
`define PDB_HI_BYTE_LSB 8

// ======================================================
// Reset values and bus responses
`define PDB_RST_BYTE 8'h00
`define PDB_RESP_OKAY 2'h0
`define PDB_RESP_SLVERR 2'h2

`endif

// ==== common/pdb_pkg.sv ====
// Types shared by the port group and its lanes
// Assumes pdb_consts.svh sits on the include path
package pdb_pkg;
	typedef logic [7:0] pdb_byte_t;
	typedef logic [5:0] pdb_idx_t;
	typedef enum logic [1:0]
	{
		PDB_LANE_A = 2'b00,
		PDB_LANE_B = 2'b01,
		PDB_LANE_C = 2'b10,
		PDB_LANE_D = 2'b11
	} pdb_lane_e;
endpackage

// ==== rtl/pdb_lane.sv ====
// One 8-bit port: output latch, write buffer and input capture latch
// Assumes request level and edge come in already polarity-corrected
`timescale 1ns/1ps
`include "pdb_consts.svh"

module pdb_lane
	import pdb_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic dir_out,
	input wire logic dbl_buf,
	input wire logic pulse_mode,
	input wire logic req_act,
	input wire logic req_edge,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_take,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] pins_out,
	output logic [WIDTH-1:0] pins_oe,
	output logic [WIDTH-1:0] rd_val,
	output logic pend
);
	logic [WIDTH-1:0] buf_ff;
	logic [WIDTH-1:0] drv_ff;
	logic [WIDTH-1:0] in_ff;
	logic pend_ff;
	logic cap;

	// ======================================================
	// Output side
	always_ff @(posedge clk)
	begin
		if (rst)
			buf_ff <= WIDTH'(`PDB_RST_BYTE);
		else if (wr_en)
			buf_ff <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			drv_ff <= WIDTH'(`PDB_RST_BYTE);
		else if (dbl_buf)
		begin
			if (req_act)
				drv_ff <= buf_ff;
		end
		else if (wr_en)
			drv_ff <= wr_data;
	end

	// ======================================================
	// Input capture
	// A read in the same cycle as a new edge frees the slot for it
	assign cap = dbl_buf && !dir_out && pulse_mode && req_edge
		&& (!pend_ff || rd_take);

	always_ff @(posedge clk)
	begin
		if (rst)
			in_ff <= WIDTH'(`PDB_RST_BYTE);
		else if (dbl_buf && !dir_out && !pulse_mode && req_act)
			in_ff <= pins_in;
		else if (cap)
			in_ff <= pins_in;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pend_ff <= 1'b0;
		else if (!dbl_buf || dir_out || !pulse_mode)
			pend_ff <= 1'b0;
		else if (cap)
			pend_ff <= 1'b1;
		else if (rd_take)
			pend_ff <= 1'b0;
	end

	assign pins_out = drv_ff;
	assign pins_oe = {WIDTH{dir_out}};
	assign pend = pend_ff;
	assign rd_val = dir_out ? drv_ff : (dbl_buf ? in_ff : pins_in);

	// ======================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_direct_drive: assert property (
		wr_en && !dbl_buf |=> pins_out == $past(wr_data))
		else $error("direct write not driven");
	a_buffer_holds: assert property (
		dbl_buf && !req_act |=> $stable(pins_out))
		else $error("buffered output moved without request");
	a_read_output: assert property (
		dir_out && !dbl_buf && wr_en |=> rd_val == $past(wr_data))
		else $error("output read differs from written value");
	a_level_follow: assert property (
		!dir_out && dbl_buf && !pulse_mode && req_act
		|=> rd_val == $past(pins_in))
		else $error("level latch not following");
	a_pulse_hold: assert property (
		pend && !rd_take && $stable(dbl_buf) && $stable(pulse_mode)
		&& $stable(dir_out) |=> pend && $stable(rd_val))
		else $error("held capture overwritten");
	a_pulse_capture: assert property (
		!dir_out && dbl_buf && pulse_mode && req_edge && !pend
		|=> rd_val == $past(pins_in))
		else $error("edge capture missed");
	c_pulse_capture: cover property (cap);
endmodule // pdb_lane

// ==== rtl/pdb_dio.sv ====
// Four 8-bit parallel ports in two request-handshaked pairs, AXI4-Lite
// Assumes direction, mode, polarity and buffering come from outside regs
// Operation
// - Four 8-bit ports in two pairs
// - Word at first port packs first, second
// - Word at third port packs third, fourth
// - Direct output write drives lines at once
// - Output read returns driven value
// - Direct input read returns line levels
// - First port buffered output released by request one
// - Second port buffered output released by request one
// - Third port buffered output released by request two
// - Fourth port buffered output released by request two
// - Pair one level mode follows while active
// - Pair one pulse mode captures on edge
// - Pair two level mode follows while active
// - Pair two pulse mode captures on edge
`timescale 1ns/1ps
`include "pdb_consts.svh"

module pdb_dio
	import pdb_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic [7:0] FIRST_PORT_BITS_IN,
	output logic [7:0] FIRST_PORT_BITS_OUT,
	output logic [7:0] FIRST_PORT_BITS_OE,
	input wire logic [7:0] SECOND_PORT_BITS_IN,
	output logic [7:0] SECOND_PORT_BITS_OUT,
	output logic [7:0] SECOND_PORT_BITS_OE,
	input wire logic [7:0] THIRD_PORT_BITS_IN,
	output logic [7:0] THIRD_PORT_BITS_OUT,
	output logic [7:0] THIRD_PORT_BITS_OE,
	input wire logic [7:0] FOURTH_PORT_BITS_IN,
	output logic [7:0] FOURTH_PORT_BITS_OUT,
	output logic [7:0] FOURTH_PORT_BITS_OE,
	input wire logic FIRST_PORT_OUTPUT,
	input wire logic SECOND_PORT_OUTPUT,
	input wire logic THIRD_PORT_OUTPUT,
	input wire logic FOURTH_PORT_OUTPUT,
	input wire logic FIRST_PORT_DOUBLE_BUFFER,
	input wire logic SECOND_PORT_DOUBLE_BUFFER,
	input wire logic THIRD_PORT_DOUBLE_BUFFER,
	input wire logic FOURTH_PORT_DOUBLE_BUFFER,
	input wire logic PAIR_ONE_PULSE_MODE,
	input wire logic PAIR_TWO_PULSE_MODE,
	input wire logic REQUEST_ONE_ACTIVE_HIGH,
	input wire logic REQUEST_TWO_ACTIVE_HIGH,
	input wire logic HANDSHAKE_REQUEST_ONE,
	input wire logic HANDSHAKE_REQUEST_TWO
);
	logic [1:0] req_act;
	logic [1:0] req_prev_ff;
	logic [1:0] req_edge;
	logic [3:0] dir_out;
	logic [3:0] dbl_buf;
	logic [3:0] lane_pulse;
	logic [3:0] lane_act;
	logic [3:0] lane_edge;
	logic [3:0] lane_wr;
	logic [3:0] lane_rd;
	logic [3:0] lane_pend;
	pdb_byte_t lane_wdata [4];
	pdb_byte_t pins_in [4];
	pdb_byte_t pins_out [4];
	pdb_byte_t pins_oe [4];
	pdb_byte_t rd_val [4];
	pdb_idx_t wr_idx;
	pdb_idx_t rd_idx;
	logic aw_go;
	logic ar_go;
	logic wr_hit;
	logic rd_hit;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [31:0] nxt_rdata;

	// ======================================================
	// Request lines
	// Polarity folded in here so lanes only see active level and edge
	assign req_act[0] = HANDSHAKE_REQUEST_ONE == REQUEST_ONE_ACTIVE_HIGH;
	assign req_act[1] = HANDSHAKE_REQUEST_TWO == REQUEST_TWO_ACTIVE_HIGH;

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			req_prev_ff <= 2'h3;
		else
			req_prev_ff <= req_act;
	end

	// Reset value of all ones blocks a false edge just after reset
	assign req_edge = req_act & ~req_prev_ff;

	// ======================================================
	// Per-lane configuration
	assign dir_out = {FOURTH_PORT_OUTPUT, THIRD_PORT_OUTPUT,
		SECOND_PORT_OUTPUT, FIRST_PORT_OUTPUT};
	assign dbl_buf = {FOURTH_PORT_DOUBLE_BUFFER, THIRD_PORT_DOUBLE_BUFFER,
		SECOND_PORT_DOUBLE_BUFFER, FIRST_PORT_DOUBLE_BUFFER};
	assign lane_pulse = {{2{PAIR_TWO_PULSE_MODE}},
		{2{PAIR_ONE_PULSE_MODE}}};
	assign lane_act = {{2{req_act[1]}}, {2{req_act[0]}}};
	assign lane_edge = {{2{req_edge[1]}}, {2{req_edge[0]}}};

	assign pins_in[PDB_LANE_A] = FIRST_PORT_BITS_IN;
	assign pins_in[PDB_LANE_B] = SECOND_PORT_BITS_IN;
	assign pins_in[PDB_LANE_C] = THIRD_PORT_BITS_IN;
	assign pins_in[PDB_LANE_D] = FOURTH_PORT_BITS_IN;

	// ======================================================
	// Address decode
	assign wr_idx = AWADDR[7:2];
	assign rd_idx = ARADDR[7:2];
	assign aw_go = AWVALID && WVALID && !bvalid_ff;
	assign ar_go = ARVALID && !rvalid_ff;
	assign wr_hit = wr_idx == `PDB_IDX_PORT_A || wr_idx == `PDB_IDX_PORT_B
		|| wr_idx == `PDB_IDX_PORT_C || wr_idx == `PDB_IDX_PORT_D;
	assign rd_hit = rd_idx == `PDB_IDX_PORT_A || rd_idx == `PDB_IDX_PORT_B
		|| rd_idx == `PDB_IDX_PORT_C || rd_idx == `PDB_IDX_PORT_D;

	// Upper lane of a pair takes the high byte at the pair's base word
	// and the low byte at its own word; its own word is byte-only
	always_comb
	begin
		lane_wr[0] = aw_go && wr_idx == `PDB_IDX_PORT_A && WSTRB[0];
		lane_wr[1] = aw_go && ((wr_idx == `PDB_IDX_PORT_A && WSTRB[1])
			|| (wr_idx == `PDB_IDX_PORT_B && WSTRB[0]));
		lane_wr[2] = aw_go && wr_idx == `PDB_IDX_PORT_C && WSTRB[0];
		lane_wr[3] = aw_go && ((wr_idx == `PDB_IDX_PORT_C && WSTRB[1])
			|| (wr_idx == `PDB_IDX_PORT_D && WSTRB[0]));
		lane_wdata[0] = WDATA[`PDB_LO_BYTE_LSB +: 8];
		lane_wdata[2] = WDATA[`PDB_LO_BYTE_LSB +: 8];
		lane_wdata[1] = (wr_idx == `PDB_IDX_PORT_A) ?
			WDATA[`PDB_HI_BYTE_LSB +: 8] : WDATA[`PDB_LO_BYTE_LSB +: 8];
		lane_wdata[3] = (wr_idx == `PDB_IDX_PORT_C) ?
			WDATA[`PDB_HI_BYTE_LSB +: 8] : WDATA[`PDB_LO_BYTE_LSB +: 8];
	end

	// A read at a pair's base word counts as a read of both ports
	always_comb
	begin
		lane_rd[0] = ar_go && rd_idx == `PDB_IDX_PORT_A;
		lane_rd[1] = ar_go && (rd_idx == `PDB_IDX_PORT_A
			|| rd_idx == `PDB_IDX_PORT_B);
		lane_rd[2] = ar_go && rd_idx == `PDB_IDX_PORT_C;
		lane_rd[3] = ar_go && (rd_idx == `PDB_IDX_PORT_C
			|| rd_idx == `PDB_IDX_PORT_D);
	end

	// ======================================================
	// Port lanes
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		pdb_lane #(
			.WIDTH(8)
		) u_lane (
			.clk(CORE_CLK),
			.rst(RST),
			.dir_out(dir_out[i]),
			.dbl_buf(dbl_buf[i]),
			.pulse_mode(lane_pulse[i]),
			.req_act(lane_act[i]),
			.req_edge(lane_edge[i]),
			.wr_en(lane_wr[i]),
			.wr_data(lane_wdata[i]),
			.rd_take(lane_rd[i]),
			.pins_in(pins_in[i]),
			.pins_out(pins_out[i]),
			.pins_oe(pins_oe[i]),
			.rd_val(rd_val[i]),
			.pend(lane_pend[i])
		);
	end

	assign FIRST_PORT_BITS_OUT = pins_out[PDB_LANE_A];
	assign FIRST_PORT_BITS_OE = pins_oe[PDB_LANE_A];
	assign SECOND_PORT_BITS_OUT = pins_out[PDB_LANE_B];
	assign SECOND_PORT_BITS_OE = pins_oe[PDB_LANE_B];
	assign THIRD_PORT_BITS_OUT = pins_out[PDB_LANE_C];
	assign THIRD_PORT_BITS_OE = pins_oe[PDB_LANE_C];
	assign FOURTH_PORT_BITS_OUT = pins_out[PDB_LANE_D];
	assign FOURTH_PORT_BITS_OE = pins_oe[PDB_LANE_D];

	// ======================================================
	// Write channel
	// Address and data are taken together; one response at a time
	assign AWREADY = aw_go;
	assign WREADY = aw_go;

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			bvalid_ff <= 1'b0;
		else if (aw_go)
			bvalid_ff <= 1'b1;
		else if (BREADY)
			bvalid_ff <= 1'b0;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			bresp_ff <= `PDB_RESP_OKAY;
		else if (aw_go)
			bresp_ff <= wr_hit ? `PDB_RESP_OKAY : `PDB_RESP_SLVERR;
	end

	assign BVALID = bvalid_ff;
	assign BRESP = bresp_ff;

	// ======================================================
	// Read channel
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		unique case (rd_idx)
			`PDB_IDX_PORT_A:
				nxt_rdata[15:0] = {rd_val[1], rd_val[0]};
			`PDB_IDX_PORT_B:
				nxt_rdata[7:0] = rd_val[1];
			`PDB_IDX_PORT_C:
				nxt_rdata[15:0] = {rd_val[3], rd_val[2]};
			`PDB_IDX_PORT_D:
				nxt_rdata[7:0] = rd_val[3];
			default:
				nxt_rdata = 32'h0000_0000;
		endcase
	end

	assign ARREADY = ar_go;

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			rvalid_ff <= 1'b0;
		else if (ar_go)
			rvalid_ff <= 1'b1;
		else if (RREADY)
			rvalid_ff <= 1'b0;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `PDB_RESP_OKAY;
		end
		else if (ar_go)
		begin
			rdata_ff <= nxt_rdata;
			rresp_ff <= rd_hit ? `PDB_RESP_OKAY : `PDB_RESP_SLVERR;
		end
	end

	assign RVALID = rvalid_ff;
	assign RDATA = rdata_ff;
	assign RRESP = rresp_ff;

	// ======================================================
	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_word_write_ab: assert property (
		aw_go && wr_idx == `PDB_IDX_PORT_A && WSTRB[1:0] == 2'h3
		&& dir_out[1:0] == 2'h3 && dbl_buf[1:0] == 2'h0
		|=> {SECOND_PORT_BITS_OUT, FIRST_PORT_BITS_OUT}
		== $past(WDATA[15:0]))
		else $error("pair one word write misplaced");
	a_word_write_cd: assert property (
		aw_go && wr_idx == `PDB_IDX_PORT_C && WSTRB[1:0] == 2'h3
		&& dir_out[3:2] == 2'h3 && dbl_buf[3:2] == 2'h0
		|=> {FOURTH_PORT_BITS_OUT, THIRD_PORT_BITS_OUT}
		== $past(WDATA[15:0]))
		else $error("pair two word write misplaced");
	a_word_read_ab: assert property (
		ar_go && rd_idx == `PDB_IDX_PORT_A
		|=> RVALID && RDATA == {16'h0000, $past(rd_val[1]),
		$past(rd_val[0])})
		else $error("pair one word read misplaced");
	a_word_read_cd: assert property (
		ar_go && rd_idx == `PDB_IDX_PORT_C
		|=> RVALID && RDATA == {16'h0000, $past(rd_val[3]),
		$past(rd_val[2])})
		else $error("pair two word read misplaced");
	a_byte_write_b: assert property (
		aw_go && wr_idx == `PDB_IDX_PORT_B && WSTRB[0] && dir_out[1]
		&& !dbl_buf[1] |=> SECOND_PORT_BITS_OUT == $past(WDATA[7:0]))
		else $error("second port byte write lost");
	a_unmapped_err: assert property (
		aw_go && !wr_hit |=> BVALID && BRESP == `PDB_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_drive_enable: assert property (
		FIRST_PORT_BITS_OE == {8{dir_out[0]}}
		&& FOURTH_PORT_BITS_OE == {8{dir_out[3]}})
		else $error("drive enable not following direction");
	a_pair_two_req: assert property (
		dbl_buf[2] && dir_out[2] && !req_act[1]
		|=> $stable(THIRD_PORT_BITS_OUT))
		else $error("third port released without request two");
	a_resp_held: assert property (
		BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	a_read_held: assert property (
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data dropped early");
	a_unmapped_read: assert property (
		ar_go && !rd_hit |=> RVALID && RRESP == `PDB_RESP_SLVERR
		&& RDATA == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_byte_write_d: assert property (
		aw_go && wr_idx == `PDB_IDX_PORT_D && WSTRB[0] && dir_out[3]
		&& !dbl_buf[3] |=> FOURTH_PORT_BITS_OUT == $past(WDATA[7:0]))
		else $error("fourth port byte write lost");
	a_byte_read_b: assert property (
		ar_go && rd_idx == `PDB_IDX_PORT_B && dir_out[1]
		|=> RDATA == {24'h00_0000, $past(SECOND_PORT_BITS_OUT)})
		else $error("second port byte read misplaced");

	c_word_write: cover property (aw_go && WSTRB[1:0] == 2'h3
		&& wr_idx == `PDB_IDX_PORT_A);
	c_word_read_cd: cover property (ar_go && rd_idx == `PDB_IDX_PORT_C);
	c_release: cover property (dbl_buf[0] && dir_out[0] && req_edge[0]);
	c_pending_read: cover property (lane_pend[3] && lane_rd[3]);
endmodule // pdb_dio

// ==== verification/pdb_ext_dev.sv ====
// Far-side parallel device: idle line levels and both request lines
// Assumes the bench commands its levels; lines the block drives win
`timescale 1ns/1ps

module pdb_ext_dev
(
	input wire logic [31:0] drv,
	input wire logic [31:0] dout,
	input wire logic [31:0] doe,
	input wire logic [1:0] req_cmd,
	output logic [31:0] din,
	output logic [1:0] req_pin
);
	// ======================================================
	// Line resolution
	// Device lets go of every line the block drives, so no contention
	assign din = (doe & dout) | (~doe & drv);
	assign req_pin = req_cmd;
endmodule // pdb_ext_dev

// ==== verification/test_parallel_port_group_double_buffer.sv ====
// Bench for the four-port group: AXI4-Lite master, queued bus checks
// Assumes pdb_ext_dev on the far side and a 10 MHz core clock
`timescale 1ns/1ps

module test_parallel_port_group_double_buffer
	import pdb_pkg::*;
;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, drv;
	logic [3:0] wstrb, outp, dbuf;
	logic [1:0] bresp, rresp, pmode, pol, req_cmd;
	wire logic [31:0] dout, doe, din;
	wire logic [1:0] req_pin;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;

	// ======================================================
	// Design and far side
	pdb_dio #(.ADDR_W(8)) dut
	(
		.CORE_CLK(clk),
		.RST(rst),
		.AWVALID(awvalid),
		.AWREADY(awready),
		.AWADDR(awaddr),
		.WVALID(wvalid),
		.WREADY(wready),
		.WDATA(wdata),
		.WSTRB(wstrb),
		.BVALID(bvalid),
		.BREADY(bready),
		.BRESP(bresp),
		.ARVALID(arvalid),
		.ARREADY(arready),
		.ARADDR(araddr),
		.RVALID(rvalid),
		.RREADY(rready),
		.RDATA(rdata),
		.RRESP(rresp),
		.FIRST_PORT_BITS_IN(din[7:0]),
		.FIRST_PORT_BITS_OUT(dout[7:0]),
		.FIRST_PORT_BITS_OE(doe[7:0]),
		.SECOND_PORT_BITS_IN(din[15:8]),
		.SECOND_PORT_BITS_OUT(dout[15:8]),
		.SECOND_PORT_BITS_OE(doe[15:8]),
		.THIRD_PORT_BITS_IN(din[23:16]),
		.THIRD_PORT_BITS_OUT(dout[23:16]),
		.THIRD_PORT_BITS_OE(doe[23:16]),
		.FOURTH_PORT_BITS_IN(din[31:24]),
		.FOURTH_PORT_BITS_OUT(dout[31:24]),
		.FOURTH_PORT_BITS_OE(doe[31:24]),
		.FIRST_PORT_OUTPUT(outp[0]),
		.SECOND_PORT_OUTPUT(outp[1]),
		.THIRD_PORT_OUTPUT(outp[2]),
		.FOURTH_PORT_OUTPUT(outp[3]),
		.FIRST_PORT_DOUBLE_BUFFER(dbuf[0]),
		.SECOND_PORT_DOUBLE_BUFFER(dbuf[1]),
		.THIRD_PORT_DOUBLE_BUFFER(dbuf[2]),
		.FOURTH_PORT_DOUBLE_BUFFER(dbuf[3]),
		.PAIR_ONE_PULSE_MODE(pmode[0]),
		.PAIR_TWO_PULSE_MODE(pmode[1]),
		.REQUEST_ONE_ACTIVE_HIGH(pol[0]),
		.REQUEST_TWO_ACTIVE_HIGH(pol[1]),
		.HANDSHAKE_REQUEST_ONE(req_pin[0]),
		.HANDSHAKE_REQUEST_TWO(req_pin[1])
	);

	pdb_ext_dev ext
	(
		.drv(drv),
		.dout(dout),
		.doe(doe),
		.req_cmd(req_cmd),
		.din(din),
		.req_pin(req_pin)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ======================================================
	// Checking and closing
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Responses are judged here against the notes the master queued
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
		else
		begin
			if (bvalid && bready)
				chk(bresp, bq.pop_front());
			if (rvalid && rready)
				chk({rresp, rdata}, rq.pop_front());
		end
	end

	// ======================================================
	// Bus master; each task starts just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e);
		int g = $urandom_range(2);
		bq.push_back(e);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		do @(posedge clk); while (!awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		// Late ready lets the response wait and must stand meanwhile
		repeat (g) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int g = $urandom_range(2);
		rq.push_back({e, d});
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		repeat (g) @(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// Lines change only while the request is inactive
	task automatic pulse(input int p, input logic [31:0] d);
		drv <= d;
		repeat (2) @(posedge clk);
		req_cmd <= req_cmd ^ 2'(1 << p);
		repeat (3) @(posedge clk);
		req_cmd <= req_cmd ^ 2'(1 << p);
		repeat (2) @(posedge clk);
		drv <= ~d;
		@(posedge clk);
	endtask

	// ======================================================
	// Main sequence
	initial
	begin
		logic [31:0] v, w, x, y, o;
		int p, m;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		drv = 32'h0;
		outp = 4'hf;
		dbuf = 4'h0;
		pmode = 2'h0;
		pol = 2'h1;
		req_cmd = 2'h2;
		o = 32'h0;
		void'($urandom(32'h4c6c_b02c));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(doe, 32'hffff_ffff);
		chk(dout, o);
		for (p = 0; p < 2; p++)
		begin
			v = $urandom;
			w = $urandom;
			wr(8'(8'h18 + 8 * p), v, 4'h3, 2'h0);
			wr(8'(8'h1c + 8 * p), w, 4'h1, 2'h0);
			rd(8'(8'h18 + 8 * p), {16'h0, w[7:0], v[7:0]}, 2'h0);
			rd(8'(8'h1c + 8 * p), {24'h0, w[7:0]}, 2'h0);
			wr(8'(8'h18 + 8 * p), w, 4'h1, 2'h0);
			o[16 * p +: 16] = {w[7:0], w[7:0]};
			chk(dout, o);
		end
		// Unmapped places answer with an error and change nothing
		wr(8'h00, $urandom, 4'hf, 2'h2);
		rd(8'h28, 32'h0, 2'h2);
		chk(dout, o);
		// Buffered outputs wait for their own request line
		dbuf <= 4'hf;
		v = $urandom;
		wr(8'h18, v, 4'h3, 2'h0);
		wr(8'h20, ~v, 4'h3, 2'h0);
		repeat (3) @(posedge clk);
		chk(dout, o);
		req_cmd <= 2'h3;
		repeat (3) @(posedge clk);
		o[15:0] = v[15:0];
		chk(dout, o);
		req_cmd <= 2'h1;
		repeat (3) @(posedge clk);
		o[31:16] = ~v[15:0];
		chk(dout, o);
		req_cmd <= 2'h2;
		dbuf <= 4'h0;
		outp <= 4'h0;
		x = $urandom;
		drv <= x;
		@(posedge clk);
		chk(doe, 32'h0);
		rd(8'h18, {16'h0, x[15:0]}, 2'h0);
		rd(8'h24, {24'h0, x[31:24]}, 2'h0);
		dbuf <= 4'hf;
		for (m = 0; m < 2; m++)
			for (p = 0; p < 2; p++)
			begin
				pmode <= {m[0], m[0]};
				x = $urandom;
				y = $urandom;
				pulse(p, x);
				pulse(p, ~x);
				w = m[0] ? x : ~x;
				rd(8'(8'h18 + 8 * p), {16'h0, w[16 * p +: 16]}, 2'h0);
				pulse(p, y);
				rd(8'(8'h18 + 8 * p), {16'h0, y[16 * p +: 16]}, 2'h0);
			end
		summarize();
	end
endmodule // test_parallel_port_group_double_buffer
